// File: hw/spp_port_pkg.sv
package spp_port_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets within the port's address range.
	localparam logic [2:0] data_offset    = 3'h0;
	localparam logic [2:0] status_offset  = 3'h1;
	localparam logic [2:0] control_offset = 3'h2;

	// Control register bit positions.
	localparam int ctl_strobe_bit = 0;
	localparam int ctl_feed_bit   = 1;
	localparam int ctl_init_bit   = 2;
	localparam int ctl_select_bit = 3;
	localparam int ctl_irq_en_bit = 4;
	localparam int ctl_dir_bit    = 5;

	// Status register bit positions.
	localparam int sts_timeout_bit = 0;
	localparam int sts_irq_bit     = 2;

	// Reset values.
	localparam logic [7:0] data_reset    = 8'h00;
	localparam logic [5:0] control_reset = 6'h00;
	localparam logic [1:0] ctl_reserved  = 2'h3;

	// Stall time before an enhanced-mode cycle counts as timed out.
	localparam int         timeout_ns     = 10000;
	localparam int         clk_period_ns  = 8;
	localparam int         timeout_width  = 11;
	localparam logic [10:0] timeout_cycles =
		11'((timeout_ns + clk_period_ns - 1) / clk_period_ns);

	// Output data buffer shape.
	localparam int fifo_width = 8;
	localparam int fifo_depth = 32;

	////////////////////////////////////////////////////////////////////////////
	// Port operating modes, supplied by the configuration logic.
	typedef enum logic [1:0] {
		mode_compat   = 2'b00,
		mode_extended = 2'b01,
		mode_epp17    = 2'b10,
		mode_epp19    = 2'b11
	} port_mode_type;

	// Enhanced-cycle time-out watcher states.
	typedef enum logic [1:0] {
		tmo_idle  = 2'b00,
		tmo_count = 2'b01,
		tmo_fired = 2'b10
	} tmo_state_type;

	// Status inputs coming back from the printer.
	typedef struct packed {
		logic busy_in;
		logic char_taken_pulse;
		logic media_exhausted_in;
		logic printer_online_in;
		logic printer_fault_in;
	} printer_status_type;

endpackage

// File: hw/spp_printer_port_regs.sv
`timescale 1ns/100ps
// Function
// - Data register at 00h, status at 01h, control at 02h.
// - Data register is 8 bits; direction from control bit 5 and mode.
// - Reads and writes happen only on the active-low read or write strobe.
// - Compatible mode writes drive the data lines; direction bit ignored.
// - Compatible mode reads return the output latch, not the lines.
// - Extended mode, direction 0: writes drive lines, reads return latch.
// - Extended mode, direction 1: reads return lines; writes only fill latch.
// - Reset clears the data output latch to zero.
// - After reset printer reset is driven low; other handshakes and interrupt float.
// - Writes to the status register are ignored.
// - Outside enhanced modes status bit 0 reads as 1.
// - Enhanced modes: bit 0 clears on entry, sets on time-out, clears on read.
// - Time-out sets only after a stall of at least 10 us.
// - Status bit 1 always reads 1.
// - Status bit 2 reads 1 except in extended mode.
// - Extended mode with interrupt enabled: bit 2 latches 0 on acknowledge rise.
// - Reading status returns bit 2 to 1.
// - Status bit 3 follows the fault input.
// - Status bit 4 follows the online input.
// - Status bit 5 follows the paper-end input.
// - Status bit 6 follows the acknowledge input.
// - Status bit 7 is the inverse of the busy input.
// - Control bit 5 sets direction in extended mode; resets to output.
// - Control bit 4 enables the acknowledge interrupt; at 0 the line floats.

////////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO; storage is flip-flops addressed by pointer.
module spp_byte_fifo #(
	parameter int width = 8,
	parameter int depth = 32
) (
	// Clock and reset.
	input  logic             sys_clk,
	input  logic             rst,
	// Filling side.
	input  logic             in_valid,
	output logic             in_ready,
	input  logic [width-1:0] in_data,
	// Draining side.
	output logic             out_valid,
	input  logic             out_ready,
	output logic [width-1:0] out_data
);
	localparam int aw = $clog2(depth);

	logic [width-1:0] mem_q [depth];
	logic [width-1:0] mem_d [depth];
	logic [aw-1:0]    wr_ptr_q;
	logic [aw-1:0]    wr_ptr_d;
	logic [aw-1:0]    rd_ptr_q;
	logic [aw-1:0]    rd_ptr_d;
	logic [aw:0]      count_q;
	logic [aw:0]      count_d;
	logic             push;
	logic             pop;

	// Handshake flags come straight from the fill count.
	assign in_ready  = count_q != (aw+1)'(depth);
	assign out_valid = count_q != '0;
	assign out_data  = mem_q[rd_ptr_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Next pointers, count and storage.
	always_comb begin
		mem_d    = mem_q;
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		count_d  = count_q;
		if (push) begin
			mem_d[wr_ptr_q] = in_data;
			wr_ptr_d        = (wr_ptr_q == aw'(depth - 1)) ? '0 : wr_ptr_q + 1'b1;
		end
		if (pop) begin
			rd_ptr_d = (rd_ptr_q == aw'(depth - 1)) ? '0 : rd_ptr_q + 1'b1;
		end
		if (push & ~pop) begin
			count_d = count_q + 1'b1;
		end else if (pop & ~push) begin
			count_d = count_q - 1'b1;
		end
	end

	// Register the FIFO state.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < depth; i++) begin
				mem_q[i] <= '0;
			end
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			mem_q    <= mem_d;
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q  <= count_d;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Standard parallel printer port registers and pin logic.
module spp_printer_port_regs (
	// Clock and reset.
	input  logic                             sys_clk,
	input  logic                             rst,
	// Host register port.
	input  logic [2:0]                       host_addr,
	input  logic [7:0]                       host_wdata,
	input  logic                             host_rd_n,
	input  logic                             host_wr_n,
	output logic [7:0]                       host_rdata,
	output logic                             host_ready,
	// Mode and enhanced-cycle stall from the configuration logic.
	input  spp_port_pkg::port_mode_type      port_mode,
	input  logic                             epp_cycle_stall,
	// Printer status inputs.
	input  spp_port_pkg::printer_status_type printer_status,
	// Printer data lines.
	input  logic [7:0]                       printer_data_lines_in,
	output logic [7:0]                       printer_data_lines_out,
	output logic                             printer_data_lines_oe,
	// Handshake outputs; strobe, feed and select are active low on the wire.
	output logic                             strobe_out,
	output logic                             strobe_oe,
	output logic                             auto_feed_out,
	output logic                             auto_feed_oe,
	output logic                             select_request_out,
	output logic                             select_request_oe,
	output logic                             printer_reset_out,
	// Port interrupt line.
	output logic                             port_interrupt_lines_out,
	output logic                             port_interrupt_lines_oe
);
	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers, one two-stage chain per bit.
	localparam int sync_bits = 13;

	logic [sync_bits-1:0] sync_raw;
	logic [sync_bits-1:0] sync_s1_q;
	logic [sync_bits-1:0] sync_s2_q;

	assign sync_raw = {printer_data_lines_in, printer_status};

	generate
		for (genvar i = 0; i < sync_bits; i++) begin : g_sync
			logic [1:0] chain_d;

			// Shift the raw level through two stages.
			always_comb begin
				chain_d = {sync_s1_q[i], sync_raw[i]};
			end

			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					sync_s1_q[i] <= 1'b1;
					sync_s2_q[i] <= 1'b1;
				end else begin
					sync_s1_q[i] <= chain_d[0];
					sync_s2_q[i] <= chain_d[1];
				end
			end
		end
	endgenerate

	spp_port_pkg::printer_status_type sts_s;
	logic [7:0]                       lines_s;

	assign sts_s   = sync_s2_q[4:0];
	assign lines_s = sync_s2_q[12:5];

	////////////////////////////////////////////////////////////////////////////
	// Mode decode and strobe edges.
	logic is_compat;
	logic is_ext;
	logic is_epp;
	logic rd_start;
	logic wr_start;
	logic rd_n_q;
	logic wr_n_q;

	assign is_compat = port_mode == spp_port_pkg::mode_compat;
	assign is_ext    = port_mode == spp_port_pkg::mode_extended;
	assign is_epp    = port_mode[1];

	// An access is taken on the first cycle its strobe is seen low.
	assign rd_start = ~host_rd_n & rd_n_q;
	assign wr_start = ~host_wr_n & wr_n_q;

	logic rd_status;
	logic wr_data;
	logic wr_control;

	// Address decode; status writes match nothing and are dropped.
	assign rd_status  = rd_start & (host_addr == spp_port_pkg::status_offset);
	assign wr_data    = wr_start & (host_addr == spp_port_pkg::data_offset);
	assign wr_control = wr_start & (host_addr == spp_port_pkg::control_offset);

	////////////////////////////////////////////////////////////////////////////
	// Output data buffer between host writes and the output latch.
	logic       fifo_in_ready;
	logic       fifo_out_valid;
	logic       fifo_out_ready;
	logic [7:0] fifo_out_data;
	logic [5:0] ctl_q;

	// Hold the latch still while software keeps the strobe asserted.
	assign fifo_out_ready = ~ctl_q[spp_port_pkg::ctl_strobe_bit];

	spp_byte_fifo #(
		.width (spp_port_pkg::fifo_width),
		.depth (spp_port_pkg::fifo_depth)
	) u_fifo (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.in_valid  (wr_data),
		.in_ready  (fifo_in_ready),
		.in_data   (host_wdata),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Enhanced-cycle time-out watcher.
	spp_port_pkg::tmo_state_type tmo_state_q;
	spp_port_pkg::tmo_state_type tmo_state_d;
	logic [spp_port_pkg::timeout_width-1:0] tmo_cnt_q;
	logic [spp_port_pkg::timeout_width-1:0] tmo_cnt_d;
	logic                                   tmo_event;

	// Count stalled cycles; fire once when the minimum stall is reached.
	always_comb begin
		tmo_state_d = tmo_state_q;
		tmo_cnt_d   = tmo_cnt_q;
		tmo_event   = 1'b0;
		case (tmo_state_q)
			spp_port_pkg::tmo_idle: begin
				tmo_cnt_d = '0;
				if (is_epp & epp_cycle_stall) begin
					tmo_state_d = spp_port_pkg::tmo_count;
					tmo_cnt_d   = 11'h001;
				end
			end
			spp_port_pkg::tmo_count: begin
				if (~is_epp | ~epp_cycle_stall) begin
					tmo_state_d = spp_port_pkg::tmo_idle;
				end else if (tmo_cnt_q == spp_port_pkg::timeout_cycles) begin
					tmo_event   = 1'b1;
					tmo_state_d = spp_port_pkg::tmo_fired;
				end else begin
					tmo_cnt_d = tmo_cnt_q + 1'b1;
				end
			end
			spp_port_pkg::tmo_fired: begin
				if (~is_epp | ~epp_cycle_stall) begin
					tmo_state_d = spp_port_pkg::tmo_idle;
				end
			end
			default: begin
				tmo_state_d = spp_port_pkg::tmo_idle;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tmo_state_q <= spp_port_pkg::tmo_idle;
			tmo_cnt_q   <= '0;
		end else begin
			tmo_state_q <= tmo_state_d;
			tmo_cnt_q   <= tmo_cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register state.
	logic [7:0] latch_q;
	logic [7:0] latch_d;
	logic [5:0] ctl_d;
	logic       hs_en_q;
	logic       hs_en_d;
	logic       tmo_flag_q;
	logic       tmo_flag_d;
	logic       irq_sts_q;
	logic       irq_sts_d;
	logic       epp_prev_q;
	logic       ack_prev_q;
	logic       ack_rise;

	assign ack_rise = sts_s.char_taken_pulse & ~ack_prev_q;

	// Next values of latch, control and the status flags.
	always_comb begin
		latch_d    = latch_q;
		ctl_d      = ctl_q;
		hs_en_d    = hs_en_q;
		tmo_flag_d = tmo_flag_q;
		irq_sts_d  = irq_sts_q;
		if (fifo_out_valid & fifo_out_ready) begin
			latch_d = fifo_out_data;
		end
		if (wr_control) begin
			ctl_d   = host_wdata[5:0];
			hs_en_d = 1'b1;
		end
		// A time-out in the same cycle as a clear still sets the flag.
		if (tmo_event) begin
			tmo_flag_d = 1'b1;
		end else if (rd_status | (is_epp & ~epp_prev_q)) begin
			tmo_flag_d = 1'b0;
		end
		// Acknowledge latch wins over the clear of a same-cycle read.
		if (is_ext & ctl_q[spp_port_pkg::ctl_irq_en_bit] & ack_rise) begin
			irq_sts_d = 1'b0;
		end else if (rd_status) begin
			irq_sts_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			latch_q    <= spp_port_pkg::data_reset;
			ctl_q      <= spp_port_pkg::control_reset;
			hs_en_q    <= 1'b0;
			tmo_flag_q <= 1'b1;
			irq_sts_q  <= 1'b1;
			epp_prev_q <= 1'b0;
			ack_prev_q <= 1'b1;
			rd_n_q     <= 1'b1;
			wr_n_q     <= 1'b1;
		end else begin
			latch_q    <= latch_d;
			ctl_q      <= ctl_d;
			hs_en_q    <= hs_en_d;
			tmo_flag_q <= tmo_flag_d;
			irq_sts_q  <= irq_sts_d;
			epp_prev_q <= is_epp;
			ack_prev_q <= sts_s.char_taken_pulse;
			rd_n_q     <= host_rd_n;
			wr_n_q     <= host_wr_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data and pin drive, all registered.
	logic       dir_in;
	logic [7:0] status_val;
	logic [7:0] control_val;
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;
	logic       ready_q;
	logic       data_oe_q;
	logic       data_oe_d;
	logic [7:0] data_out_q;
	logic       irq_q;
	logic       irq_d;
	logic       irq_oe_q;
	logic [3:0] hs_q;
	logic [3:0] hs_d;
	logic       hs_oe_q;

	// Enhanced modes run standard cycles as extended mode does.
	assign dir_in = ~is_compat & ctl_q[spp_port_pkg::ctl_dir_bit];

	assign status_val = {
		~sts_s.busy_in,
		sts_s.char_taken_pulse,
		sts_s.media_exhausted_in,
		sts_s.printer_online_in,
		sts_s.printer_fault_in,
		is_ext ? irq_sts_q : 1'b1,
		1'b1,
		is_epp ? tmo_flag_q : 1'b1
	};

	// Direction bit reads 1 in the standard modes.
	assign control_val = {
		spp_port_pkg::ctl_reserved,
		is_epp ? ctl_q[spp_port_pkg::ctl_dir_bit] : 1'b1,
		ctl_q[4:0]
	};

	// Select read data, pin levels and interrupt level.
	always_comb begin
		rdata_d = rdata_q;
		if (rd_start) begin
			case (host_addr)
				spp_port_pkg::data_offset: begin
					rdata_d = dir_in ? lines_s : latch_q;
				end
				spp_port_pkg::status_offset: begin
					rdata_d = status_val;
				end
				spp_port_pkg::control_offset: begin
					rdata_d = control_val;
				end
				default: begin
					rdata_d = 8'hff;
				end
			endcase
		end
		data_oe_d = ~dir_in;
		hs_d = {
			~ctl_q[spp_port_pkg::ctl_select_bit],
			ctl_q[spp_port_pkg::ctl_init_bit],
			~ctl_q[spp_port_pkg::ctl_feed_bit],
			~ctl_q[spp_port_pkg::ctl_strobe_bit]
		};
		if (is_ext) begin
			irq_d = ~irq_sts_q;
		end else if (is_epp) begin
			irq_d = sts_s.char_taken_pulse | tmo_event;
		end else begin
			irq_d = sts_s.char_taken_pulse;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdata_q    <= 8'h00;
			ready_q    <= 1'b0;
			data_oe_q  <= 1'b0;
			data_out_q <= spp_port_pkg::data_reset;
			hs_q       <= 4'h0;
			hs_oe_q    <= 1'b0;
			irq_q      <= 1'b0;
			irq_oe_q   <= 1'b0;
		end else begin
			rdata_q    <= rdata_d;
			ready_q    <= fifo_in_ready;
			data_oe_q  <= data_oe_d;
			data_out_q <= latch_q;
			hs_q       <= hs_d;
			hs_oe_q    <= hs_en_q;
			irq_q      <= irq_d;
			irq_oe_q   <= ctl_q[spp_port_pkg::ctl_irq_en_bit];
		end
	end

	// Output ports.
	assign host_rdata               = rdata_q;
	assign host_ready               = ready_q;
	assign printer_data_lines_out   = data_out_q;
	assign printer_data_lines_oe    = data_oe_q;
	assign strobe_out               = hs_q[0];
	assign strobe_oe                = hs_oe_q;
	assign auto_feed_out            = hs_q[1];
	assign auto_feed_oe             = hs_oe_q;
	assign printer_reset_out        = hs_q[2];
	assign select_request_out       = hs_q[3];
	assign select_request_oe        = hs_oe_q;
	assign port_interrupt_lines_out = irq_q;
	assign port_interrupt_lines_oe  = irq_oe_q;
endmodule

// File: test/spp_printer_model.sv
`timescale 1ns/100ps
// Printer on the far side: a strobe makes it busy, then it pulses acknowledge low.
module spp_printer_model #(
	parameter int busy_cycles = 20,
	parameter int ack_cycles  = 12
) (
	// Clock.
	input  logic                             sys_clk,
	// Pins from the port.
	input  logic [7:0]                       data_out,
	input  logic                             data_oe,
	input  logic                             strobe_out,
	input  logic                             strobe_oe,
	// Printer levels set by the bench: paper end, online, fault.
	input  logic [2:0]                       panel,
	input  logic                             drive_en,
	input  logic [7:0]                       drive_value,
	// Pins back to the port.
	output spp_port_pkg::printer_status_type printer_status,
	output logic [7:0]                       data_lines
);
	int         count = 0;
	logic       seen_q = 1'b0;
	logic [7:0] last_q = 8'h00;

	// A new strobe starts the busy and acknowledge sequence.
	always @(posedge sys_clk) begin
		seen_q <= strobe_oe && !strobe_out;
		last_q <= data_lines;
		if (count > 0)
			count <= count - 1;
		else if (strobe_oe && !strobe_out && !seen_q)
			count <= busy_cycles + ack_cycles;
	end

	// Status levels; acknowledge goes low for the last part of busy.
	assign printer_status.busy_in            = count > 0;
	assign printer_status.char_taken_pulse   = !(count > 0 && count <= ack_cycles);
	assign printer_status.media_exhausted_in = panel[2];
	assign printer_status.printer_online_in  = panel[1];
	assign printer_status.printer_fault_in   = panel[0];

	// Undriven lines do not keep their last value, so they toggle.
	assign data_lines = data_oe ? data_out : drive_en ? drive_value : ~last_q;
endmodule

// File: test/spp_printer_port_regs_sva.sv
`timescale 1ns/100ps
// Port-level checks on the printer port registers.
module spp_port_checker (
	// Clock and reset.
	input logic                             sys_clk,
	input logic                             rst,
	// Host register port.
	input logic [2:0]                       host_addr,
	input logic                             host_rd_n,
	input logic                             host_wr_n,
	input logic [7:0]                       host_rdata,
	// Mode and printer status.
	input spp_port_pkg::port_mode_type      port_mode,
	input spp_port_pkg::printer_status_type printer_status,
	// Pin outputs.
	input logic [7:0]                       printer_data_lines_out,
	input logic                             printer_data_lines_oe,
	input logic                             strobe_oe,
	input logic                             auto_feed_oe,
	input logic                             select_request_oe,
	input logic                             printer_reset_out,
	input logic                             port_interrupt_lines_oe
);
	// All checks use the system clock and rest during reset.
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	chk_reset_pins: assert property (
		$fell(rst) |-> !printer_reset_out && !strobe_oe && !auto_feed_oe
			&& !select_request_oe && !port_interrupt_lines_oe)
		else $error("pin state wrong after reset");
	chk_float_hold: assert property (
		host_wr_n && $past(host_wr_n) && !strobe_oe |=> !strobe_oe)
		else $error("strobe driven without a control write");
	chk_status_ro: assert property (
		$fell(host_wr_n) && host_addr == 3'h1
			|=> ($stable(printer_data_lines_out) && $stable(printer_data_lines_oe))[*3])
		else $error("status write changed the port");
	chk_unmapped_rd: assert property (
		$fell(host_rd_n) && host_addr > 3'h2 |=> host_rdata == 8'hff)
		else $error("unmapped read not ff");
	chk_status_fixed: assert property (
		$fell(host_rd_n) && host_addr == 3'h1 |=> host_rdata[1])
		else $error("reserved status bit not 1");
	chk_compat_sts: assert property (
		$fell(host_rd_n) && host_addr == 3'h1 && $stable(port_mode)
			&& port_mode == spp_port_pkg::mode_compat |=> host_rdata[2] && host_rdata[0])
		else $error("status flag bits not 1 in compatible mode");
	chk_status_lines: assert property (
		$fell(host_rd_n) && host_addr == 3'h1 && $stable(printer_status)
			&& printer_status == $past(printer_status, 2)
			|=> host_rdata[7:3] == ($past(printer_status) ^ 5'h10))
		else $error("status bits do not mirror printer inputs");
	chk_compat_drive: assert property (
		port_mode == spp_port_pkg::mode_compat && $stable(port_mode)
			|=> printer_data_lines_oe)
		else $error("data lines not driven in compatible mode");
endmodule

bind spp_printer_port_regs spp_port_checker spp_port_checker_i (
	.sys_clk(sys_clk), .rst(rst), .host_addr(host_addr), .host_rd_n(host_rd_n),
	.host_wr_n(host_wr_n), .host_rdata(host_rdata), .port_mode(port_mode),
	.printer_status(printer_status), .printer_data_lines_out(printer_data_lines_out),
	.printer_data_lines_oe(printer_data_lines_oe), .strobe_oe(strobe_oe),
	.auto_feed_oe(auto_feed_oe), .select_request_oe(select_request_oe),
	.printer_reset_out(printer_reset_out),
	.port_interrupt_lines_oe(port_interrupt_lines_oe));

// File: test/spp_printer_port_regs_bench.sv
`timescale 1ns/100ps
// Self-checking bench for the printer port registers.
module spp_printer_port_regs_bench;
	logic                             sys_clk = 1'b0, rst = 1'b1;
	logic [2:0]                       host_addr = 3'h0, panel = 3'h3;
	logic [7:0]                       host_wdata = 8'h00, drive_value = 8'h00;
	logic                             host_rd_n = 1'b1, host_wr_n = 1'b1;
	logic                             epp_cycle_stall = 1'b0, drive_en = 1'b0;
	spp_port_pkg::port_mode_type      port_mode = spp_port_pkg::mode_compat;
	spp_port_pkg::printer_status_type printer_status;
	logic [7:0]                       host_rdata, lines_in, lines_out, rd;
	logic                             host_ready, lines_oe, strobe_out, strobe_oe;
	logic                             feed_oe, select_oe, init_out, irq_oe;
	logic                             feed_out, select_out, irq_out;
	int                               fails = 0, compares = 0;

	// Design and printer.
	spp_printer_port_regs spp_printer_port_regs_i (
		.sys_clk(sys_clk), .rst(rst), .host_addr(host_addr), .host_wdata(host_wdata),
		.host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_rdata(host_rdata),
		.host_ready(host_ready), .port_mode(port_mode), .epp_cycle_stall(epp_cycle_stall),
		.printer_status(printer_status), .printer_data_lines_in(lines_in),
		.printer_data_lines_out(lines_out), .printer_data_lines_oe(lines_oe),
		.strobe_out(strobe_out), .strobe_oe(strobe_oe), .auto_feed_out(feed_out),
		.auto_feed_oe(feed_oe), .select_request_out(select_out),
		.select_request_oe(select_oe),
		.printer_reset_out(init_out), .port_interrupt_lines_out(irq_out),
		.port_interrupt_lines_oe(irq_oe));
	spp_printer_model spp_printer_model_i (
		.sys_clk(sys_clk), .data_out(lines_out), .data_oe(lines_oe),
		.strobe_out(strobe_out), .strobe_oe(strobe_oe), .panel(panel),
		.drive_en(drive_en), .drive_value(drive_value),
		.printer_status(printer_status), .data_lines(lines_in));

	// Clock of 8 ns.
	always #4 sys_clk = ~sys_clk;

	// Comparisons of bytes and of single bits.
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t byte %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t bit %b expected %b", $time, got, exp);
		end
	endtask

	// Waits for clock edges and lands just after the last one.
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// Host cycles: the strobe is low over one edge, then high again.
	task automatic host_write(input logic [2:0] a, input logic [7:0] d);
		host_addr = a;
		host_wdata = d;
		host_wr_n = 1'b0;
		tick(1);
		host_wr_n = 1'b1;
		tick(4);
	endtask
	task automatic host_read(input logic [2:0] a, output logic [7:0] d);
		host_addr = a;
		host_rd_n = 1'b0;
		tick(1);
		host_rd_n = 1'b1;
		d = host_rdata;
		tick(1);
	endtask

	// Pins and registers straight out of reset.
	task automatic test_reset();
		check_bit(init_out, 1'b0);
		check_bit(strobe_oe | feed_oe | select_oe | irq_oe, 1'b0);
		host_read(3'h0, rd);
		check_byte(rd, 8'h00);
		host_read(3'h2, rd);
		check_byte(rd, 8'he0);
		host_write(3'h3, 8'h77);
		host_read(3'h5, rd);
		check_byte(rd, 8'hff);
	endtask

	// Compatible mode drives the lines even with the direction bit set.
	task automatic test_compat();
		host_write(3'h2, 8'h24);
		check_bit(init_out, 1'b1);
		check_bit(feed_out & select_out, 1'b1);
		host_write(3'h0, 8'ha5);
		check_bit(lines_oe, 1'b1);
		check_byte(lines_out, 8'ha5);
		host_wdata = 8'h11;
		tick(4);
		check_byte(lines_out, 8'ha5);
		host_read(3'h0, rd);
		check_byte(rd, 8'ha5);
	endtask

	// Extended mode in both directions.
	task automatic test_extended();
		port_mode = spp_port_pkg::mode_extended;
		drive_en = 1'b1;
		drive_value = 8'h3c;
		tick(3);
		check_bit(lines_oe, 1'b0);
		host_read(3'h0, rd);
		check_byte(rd, 8'h3c);
		host_write(3'h0, 8'h99);
		check_bit(lines_oe, 1'b0);
		check_byte(lines_in, 8'h3c);
		drive_en = 1'b0;
		host_write(3'h2, 8'h04);
		check_bit(lines_oe, 1'b1);
		check_byte(lines_out, 8'h99);
		host_read(3'h0, rd);
		check_byte(rd, 8'h99);
	endtask

	// Every panel combination shows in the status byte; writes leave it alone.
	task automatic test_status();
		port_mode = spp_port_pkg::mode_compat;
		for (int i = 0; i < 8; i++) begin
			panel = i[2:0];
			tick(3);
			host_read(3'h1, rd);
			check_byte(rd, {2'b11, i[2:0], 3'b111});
		end
		host_write(3'h1, 8'h00);
		host_read(3'h1, rd);
		check_byte(rd, 8'hff);
		panel = 3'h3;
	endtask

	// Acknowledge after a strobe latches the interrupt flag in extended mode.
	task automatic test_irq();
		port_mode = spp_port_pkg::mode_extended;
		host_write(3'h2, 8'h14);
		check_bit(irq_oe, 1'b1);
		host_read(3'h1, rd);
		check_bit(rd[2], 1'b1);
		host_write(3'h2, 8'h15);
		tick(3);
		host_read(3'h1, rd);
		check_bit(rd[7], 1'b0);
		host_write(3'h2, 8'h14);
		tick(40);
		check_bit(irq_out, 1'b1);
		host_read(3'h1, rd);
		check_bit(rd[2], 1'b0);
		check_bit(irq_out, 1'b0);
		host_read(3'h1, rd);
		check_bit(rd[2], 1'b1);
	endtask

	// Buffer filled while strobe holds it, overflow dropped, then drained in order.
	task automatic test_fifo();
		logic [7:0] seen[$];
		logic [7:0] prev;
		port_mode = spp_port_pkg::mode_compat;
		host_write(3'h2, 8'h05);
		for (int i = 0; i < 32; i++) begin
			check_bit(host_ready, 1'b1);
			host_write(3'h0, 8'h40 + i[7:0]);
		end
		check_bit(host_ready, 1'b0);
		host_write(3'h0, 8'hee);
		prev = lines_out;
		fork
			host_write(3'h2, 8'h04);
			repeat (120) begin
				tick(1);
				if (lines_out !== prev)
					seen.push_back(lines_out);
				prev = lines_out;
			end
		join
		check_bit(seen.size() == 32, 1'b1);
		for (int i = 0; i < 32; i++)
			check_byte(i < seen.size() ? seen[i] : 8'hxx, 8'h40 + i[7:0]);
	endtask

	// Time-out flag in both enhanced modes, just under and over the limit.
	task automatic test_timeout();
		for (int m = 2; m < 4; m++) begin
			port_mode = spp_port_pkg::mode_compat;
			tick(3);
			host_read(3'h1, rd);
			check_bit(rd[0], 1'b1);
			port_mode = spp_port_pkg::port_mode_type'(m[1:0]);
			tick(3);
			host_read(3'h1, rd);
			check_bit(rd[0], 1'b0);
			epp_cycle_stall = 1'b1;
			tick(1200);
			epp_cycle_stall = 1'b0;
			host_read(3'h1, rd);
			check_bit(rd[0], 1'b0);
			epp_cycle_stall = 1'b1;
			tick(1260);
			epp_cycle_stall = 1'b0;
			host_read(3'h1, rd);
			check_bit(rd[0], 1'b1);
			host_read(3'h1, rd);
			check_bit(rd[0], 1'b0);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic tally_and_finish();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Main sequence after a reset of 3 cycles.
	initial begin
		tick(3);
		rst = 1'b0;
		tick(2);
		test_reset();
		test_compat();
		test_extended();
		test_status();
		test_irq();
		test_fifo();
		test_timeout();
		tally_and_finish();
	end

	// Cuts a hang short well after the expected 5400 cycles.
	initial begin
		#200000;
		fails++;
		tally_and_finish();
	end
endmodule
